// ===== src/vr_pkg.sv
package vr_pkg;

  // Phase current sample width and phase count limits
  localparam int CUR_W = 12;
  localparam int MAX_PH = 4;
  localparam int SUM_W = CUR_W + 2;
  localparam int ERR_W = CUR_W + 1;
  localparam int REF_W = 14;

  // Reference levels in units of 0.1 mV
  localparam logic [REF_W-1:0] REF_HI_TOP = 14'h3C8C;  // 1.5500 V
  localparam logic [REF_W-1:0] REF_HI_STEP = 14'h00FA; // 25 mV
  localparam logic [REF_W-1:0] REF_LO_TOP = 14'h1DC9;  // 0.7625 V
  localparam logic [REF_W-1:0] REF_LO_STEP = 14'h007D; // 12.5 mV

  // Mode select pin level meaning, sampled at enable rise
  localparam logic MODE_SERIAL = 1'h0;
  localparam logic MODE_PARALLEL = 1'h1;
  localparam logic MODE_RESET = MODE_SERIAL;

  // Active phase counts
  localparam logic [2:0] PH_CNT_2 = 3'h2;
  localparam logic [2:0] PH_CNT_3 = 3'h3;
  localparam logic [2:0] PH_CNT_4 = 3'h4;

  // Mode select setup time before enable rises
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SEL_SETUP_NS = 1;
  localparam int SEL_SETUP_CYC =
    (SEL_SETUP_NS * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETUP_CNT_W = $clog2(SEL_SETUP_CYC + 1);

  // Switching period default in system clocks and error filter shift
  localparam int SW_PERIOD_DEF = 200;
  localparam int FILT_SH = 3;

  typedef enum {BAL_IDLE, BAL_DIV, BAL_APPLY} bal_state_t;

endpackage

// ===== src/avg_divider.sv
`timescale 1ns/1ps
module avg_divider
  import vr_pkg::*;
#(
  parameter int DW = SUM_W
) (
  input wire logic sys_clk_i,          // System clock
  input wire logic rstn_i,             // Async reset, active low
  input wire logic start_i,            // Load operands, one-cycle pulse
  input wire logic [DW-1:0] dividend_i, // Sum to divide
  input wire logic [2:0] divisor_i,    // Divisor, nonzero
  output logic done_o,                 // Quotient valid, one-cycle pulse
  output logic [DW-1:0] quotient_o     // Registered quotient
);

  localparam int CW = $clog2(DW + 1);

  // The shift path needs at least two quotient bits
  if (DW < 2) begin : g_bad_width
    $error("DW must be at least 2");
  end

  logic [DW-1:0] rem, next_rem;
  logic [DW-1:0] quo, next_quo;
  logic [2:0] div, next_div;
  logic [CW-1:0] cnt, next_cnt;
  logic busy, next_busy;
  logic done, next_done;
  logic [DW:0] trial;

  // Restoring division, one quotient bit per clock; DW clocks in total
  always_comb begin
    next_rem = rem;
    next_quo = quo;
    next_div = div;
    next_cnt = cnt;
    next_busy = busy;
    next_done = 1'h0;
    trial = {rem, quo[DW-1]};
    if (start_i) begin
      next_rem = '0;
      next_quo = dividend_i;
      next_div = divisor_i;
      next_cnt = CW'(DW);
      next_busy = 1'h1;
    end else if (busy) begin
      if (trial >= (DW+1)'(div)) begin
        next_rem = DW'(trial - (DW+1)'(div));
        next_quo = {quo[DW-2:0], 1'h1};
      end else begin
        next_rem = DW'(trial);
        next_quo = {quo[DW-2:0], 1'h0};
      end
      next_cnt = cnt - CW'(1);
      if (cnt == CW'(1)) begin
        next_busy = 1'h0;
        next_done = 1'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rem <= '0;
      quo <= '0;
      div <= 3'h1;
      cnt <= '0;
      busy <= 1'h0;
      done <= 1'h0;
    end else begin
      rem <= next_rem;
      quo <= next_quo;
      div <= next_div;
      cnt <= next_cnt;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign done_o = done;
  assign quotient_o = quo;

endmodule

// ===== src/vr_mode_balance.sv
`timescale 1ns/1ps
// Function
// [R1] Enable low keeps core and auxiliary regulators off; select pin sampled.
// [R2] Select pin level is captured into mode on enable rising edge.
// [R3] Captured low selects serial code mode, high selects parallel mode.
// [R4] Mode holds while enable stays high, until the next rising edge.
// [R5] Parallel code mode keeps auxiliary regulator off, core only.
// [R6] Codes 0..31 give 1.5500 V down to 0.7750 V, 25 mV steps.
// [R7] Codes 32..63 give 0.7625 V down to 0.3750 V, 12.5 mV steps.
// [R8] Each switching cycle, average of active phase samples is formed.
// [R9] Per active phase, filtered error versus average trims pulse width.
// [R10] Phase3 sense high gives 2 phases, else phase4 high 3, else 4.
module vr_mode_balance
  import vr_pkg::*;
#(
  parameter int SW_PERIOD = SW_PERIOD_DEF
) (
  input wire logic sys_clk_i,                     // System clock, 200 MHz
  input wire logic rstn_i,                        // Async reset, active low
  input wire logic enable_i,                      // Enable pin
  input wire logic mode_select_pin_i,             // Mode select pin
  input wire logic [5:0] code_i,                  // Parallel code, code_bit_5 MSB
  input wire logic phase3_sense_neg_i,            // High when tied to supply
  input wire logic phase4_sense_neg_i,            // High when tied to supply
  input wire logic [MAX_PH-1:0][CUR_W-1:0] phase_current_i, // Sampled currents
  output logic core_enable_o,                     // Multiphase core runs
  output logic aux_enable_o,                      // Auxiliary regulator runs
  output logic parallel_code_mode_o,              // 1 parallel, 0 serial
  output logic mode_setup_ok_o,                   // Select stable before rise
  output logic [REF_W-1:0] ref_level_o,           // Reference, 0.1 mV units
  output logic [2:0] active_phases_o,             // Active phase count
  output logic [CUR_W-1:0] cycle_average_current_o, // Cycle average
  output logic [MAX_PH-1:0][ERR_W-1:0] balance_trim_o // Signed width trims
);

  // The divider must finish well inside one switching cycle
  if (SW_PERIOD < SUM_W + 4) begin : g_bad_period
    $error("SW_PERIOD too short for the averaging divider");
  end

  localparam int SWC_W = $clog2(SW_PERIOD);

  // Two-flop synchronisers for the enable, select, sense and code pins
  logic [9:0] pin_s1, pin_s2;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= {enable_i, mode_select_pin_i, phase3_sense_neg_i,
                 phase4_sense_neg_i, code_i};
      pin_s2 <= pin_s1;
    end
  end
  logic en_s, sel_s, ph3_s, ph4_s;
  logic [5:0] code_s;
  assign {en_s, sel_s, ph3_s, ph4_s, code_s} = pin_s2;

  // Mode capture, phase detection, reference decode
  logic en_d, next_en_d;
  logic mode, next_mode;
  logic setup_ok, next_setup_ok;
  logic sel_d, next_sel_d;
  logic [SETUP_CNT_W-1:0] stab_cnt, next_stab_cnt;
  logic [2:0] nph, next_nph;
  logic [REF_W-1:0] ref_lvl, next_ref_lvl;
  logic en_rise;

  assign en_rise = en_s & ~en_d;

  always_comb begin
    next_en_d = en_s;
    next_sel_d = sel_s;
    next_mode = mode;
    next_setup_ok = setup_ok;
    next_nph = nph;
    next_stab_cnt = stab_cnt;
    // Select level is watched continuously, with enable low or high
    if (sel_s != sel_d)
      next_stab_cnt = '0;                                    // [R1]
    else if (stab_cnt != SETUP_CNT_W'(SEL_SETUP_CYC))
      next_stab_cnt = stab_cnt + SETUP_CNT_W'(1);
    if (en_rise) begin
      next_mode = sel_s ? MODE_PARALLEL : MODE_SERIAL;      // [R2] [R3] [R4]
      next_setup_ok = (stab_cnt == SETUP_CNT_W'(SEL_SETUP_CYC));
    end
    // Phase count follows the sense pins only while stopped
    if (!en_s) begin
      if (ph3_s)
        next_nph = PH_CNT_2;                                 // [R10]
      else if (ph4_s)
        next_nph = PH_CNT_3;                                 // [R10]
      else
        next_nph = PH_CNT_4;                                 // [R10]
    end
    if (!code_s[5])
      next_ref_lvl = REF_HI_TOP - REF_W'(code_s[4:0]) * REF_HI_STEP; // [R6]
    else
      next_ref_lvl = REF_LO_TOP - REF_W'(code_s[4:0]) * REF_LO_STEP; // [R7]
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en_d <= 1'h0;
      sel_d <= 1'h0;
      mode <= MODE_RESET;
      setup_ok <= 1'h0;
      stab_cnt <= '0;
      nph <= PH_CNT_4;
      ref_lvl <= '0;
    end else begin
      en_d <= next_en_d;
      sel_d <= next_sel_d;
      mode <= next_mode;
      setup_ok <= next_setup_ok;
      stab_cnt <= next_stab_cnt;
      nph <= next_nph;
      ref_lvl <= next_ref_lvl;
    end
  end

  // Enable is one cycle behind en_s so a fresh mode is never missed
  assign core_enable_o = en_d;                               // [R1]
  assign aux_enable_o = en_d & (mode == MODE_SERIAL);        // [R1] [R5]
  assign parallel_code_mode_o = mode;
  assign mode_setup_ok_o = setup_ok;
  assign ref_level_o = ref_lvl;
  assign active_phases_o = nph;

  // Switching cycle tick from a divider, only while the core runs
  logic [SWC_W-1:0] sw_cnt, next_sw_cnt;
  logic sw_tick;
  assign sw_tick = en_d && (sw_cnt == '0);
  always_comb begin
    if (!en_d || sw_cnt == SWC_W'(SW_PERIOD - 1))
      next_sw_cnt = '0;
    else
      next_sw_cnt = sw_cnt + SWC_W'(1);
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      sw_cnt <= '0;
    else
      sw_cnt <= next_sw_cnt;
  end

  // Current balance
  bal_state_t state, next_state;
  logic [MAX_PH-1:0][CUR_W-1:0] samp, next_samp;
  logic [SUM_W-1:0] sum_q, next_sum_q, sum_c;
  logic [CUR_W-1:0] avg, next_avg;
  logic [MAX_PH-1:0][ERR_W-1:0] acc, next_acc, upd_acc;
  logic div_start, div_done;
  logic [SUM_W-1:0] quot;

  always_comb begin
    sum_c = '0;
    for (int p = 0; p < MAX_PH; p++)
      if (p < int'(nph))
        sum_c = sum_c + SUM_W'(phase_current_i[p]);          // [R8]
  end

  // Leaky integrator per phase; the shift sets the filter bandwidth
  for (genvar p = 0; p < MAX_PH; p++) begin : g_phase
    logic signed [ERR_W:0] err;
    logic signed [ERR_W:0] delta;
    always_comb begin
      err = $signed({2'h0, avg}) - $signed({2'h0, samp[p]}); // [R9]
      delta = (err - $signed({acc[p][ERR_W-1], acc[p]})) >>> FILT_SH;
      if (p < int'(nph))
        upd_acc[p] = ERR_W'($signed({acc[p][ERR_W-1], acc[p]}) + delta);
      else
        upd_acc[p] = '0;                                     // [R9]
    end
  end

  always_comb begin
    next_state = state;
    next_samp = samp;
    next_sum_q = sum_q;
    next_avg = avg;
    next_acc = acc;
    div_start = 1'h0;
    unique case (state)
      BAL_IDLE: begin
        if (sw_tick) begin
          next_samp = phase_current_i;                       // [R8]
          next_sum_q = sum_c;
          div_start = 1'h1;
          next_state = BAL_DIV;
        end
      end
      BAL_DIV: begin
        if (div_done) begin
          next_avg = CUR_W'(quot);                           // [R8]
          next_state = BAL_APPLY;
        end
      end
      BAL_APPLY: begin
        next_acc = upd_acc;                                  // [R9]
        next_state = BAL_IDLE;
      end
    endcase
    // Trims restart from zero whenever the core is stopped
    if (!en_d)
      next_acc = '0;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= BAL_IDLE;
      samp <= '0;
      sum_q <= '0;
      avg <= '0;
      acc <= '0;
    end else begin
      state <= next_state;
      samp <= next_samp;
      sum_q <= next_sum_q;
      avg <= next_avg;
      acc <= next_acc;
    end
  end

  avg_divider #(
    .DW(SUM_W)
  ) u_div (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .start_i(div_start),
    .dividend_i(sum_c),
    .divisor_i(nph),
    .done_o(div_done),
    .quotient_o(quot)
  );

  assign cycle_average_current_o = avg;
  assign balance_trim_o = acc;

  // Checks
  a_core_off_low: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !en_s ##1 1 |-> !core_enable_o && !aux_enable_o) // [R1]
    else $error("regulator enabled while enable low");
  a_mode_capture: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    en_rise |=> parallel_code_mode_o == $past(sel_s)) // [R2]
    else $error("mode not captured at enable rise");
  a_mode_serial: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    en_rise && !sel_s |=> !parallel_code_mode_o && aux_enable_o) // [R3]
    else $error("low select did not give serial mode");
  a_mode_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    en_d && en_s && !en_rise |=> $stable(parallel_code_mode_o)) // [R4]
    else $error("mode changed while enable high");
  a_aux_off_par: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    parallel_code_mode_o |-> !aux_enable_o) // [R5]
    else $error("auxiliary on in parallel mode");
  a_ref_upper: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !code_s[5] |=> ref_level_o ==
      14'h3C8C - 14'h00FA * 14'($past(code_s[4:0]))) // [R6]
    else $error("upper code range reference wrong");
  a_ref_lower: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    code_s[5] |=> ref_level_o ==
      14'h1DC9 - 14'h007D * 14'($past(code_s[4:0]))) // [R7]
    else $error("lower code range reference wrong");
  a_avg_exact: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == BAL_APPLY |-> 17'(avg) * 17'(nph) <= 17'(sum_q) &&
      17'(sum_q) < (17'(avg) + 17'h1) * 17'(nph)) // [R8]
    else $error("cycle average is not sum over phases");
  a_avg_timely: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    div_start |-> ##[1:20] state == BAL_APPLY) // [R8]
    else $error("average not ready in time");
  a_trim_idle: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    nph == PH_CNT_2 && state == BAL_APPLY |=>
      balance_trim_o[2] == '0 && balance_trim_o[3] == '0) // [R9]
    else $error("inactive phase has a trim");
  a_phase_cnt: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !en_s && ph3_s |=> active_phases_o == 3'h2) // [R10]
    else $error("phase3 sense did not select two phases");

  c_serial: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    en_rise && !sel_s ##1 !parallel_code_mode_o);
  c_parallel: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    en_rise && sel_s ##1 parallel_code_mode_o);
  c_three_ph: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    nph == PH_CNT_3 && state == BAL_APPLY);
  c_trim_set: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    state == BAL_APPLY ##1 balance_trim_o[0] != '0);

endmodule

// ===== bench/host_model.sv
`timescale 1ns/1ps
module host_model
  import vr_pkg::*;
(
  input wire logic sys_clk_i,                  // System clock
  output logic enable_o,                       // Enable pin
  output logic mode_select_o,                  // Mode select pin
  output logic [5:0] code_o,                   // Parallel code
  output logic s3_o,                           // Phase 3 sense tie
  output logic s4_o,                           // Phase 4 sense tie
  output logic [MAX_PH-1:0][CUR_W-1:0] cur_o   // Phase current samples
);
  // Phases sit off the average so each active trim is nonzero, except phase 2 in three-phase runs
  initial begin
    enable_o = 1'h0;
    mode_select_o = 1'h0;
    code_o = 6'h00;
    s3_o = 1'h0;
    s4_o = 1'h0;
    for (int i = 0; i < MAX_PH; i++) cur_o[i] = CUR_W'(100 * (i + 1));
  end

  // Pins move just after an edge so no edge races them
  task automatic set_pins(input logic sel, input logic s3, input logic s4,
                          input logic [5:0] code);
    @(posedge sys_clk_i);
    #1;
    mode_select_o = sel;
    s3_o = s3;
    s4_o = s4;
    code_o = code;
  endtask

  task automatic set_enable(input logic en);
    @(posedge sys_clk_i);
    #1;
    enable_o = en;
  endtask
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  errors++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb;
  import vr_pkg::*;
  localparam int SWP = 40;
  typedef struct packed {
    logic sel; logic s3; logic s4; logic [5:0] code; logic [2:0] ph;
  } row_t;
  logic sys_clk, rst_n, en, sel, s3, s4, core_en, aux_en, par, setup_ok;
  logic [5:0] code;
  logic [MAX_PH-1:0][CUR_W-1:0] cur;
  logic [REF_W-1:0] ref_lvl;
  logic [2:0] phases;
  logic [CUR_W-1:0] avg;
  logic [MAX_PH-1:0][ERR_W-1:0] trim;
  int errors, n_checks, cyc;
  row_t rows [6] = '{'{1'h1, 1'h0, 1'h0, 6'h00, 3'h4},
                     '{1'h0, 1'h0, 1'h1, 6'h1F, 3'h3},
                     '{1'h1, 1'h1, 1'h0, 6'h20, 3'h2},
                     '{1'h0, 1'h1, 1'h1, 6'h3F, 3'h2},
                     '{1'h1, 1'h0, 1'h1, 6'h01, 3'h3},
                     '{1'h0, 1'h0, 1'h0, 6'h21, 3'h4}};

  host_model i_host (.sys_clk_i(sys_clk), .enable_o(en), .mode_select_o(sel),
    .code_o(code), .s3_o(s3), .s4_o(s4), .cur_o(cur));

  vr_mode_balance #(.SW_PERIOD(SWP)) i_dut (.sys_clk_i(sys_clk),
    .rstn_i(rst_n), .enable_i(en), .mode_select_pin_i(sel), .code_i(code),
    .phase3_sense_neg_i(s3), .phase4_sense_neg_i(s4), .phase_current_i(cur),
    .core_enable_o(core_en), .aux_enable_o(aux_en),
    .parallel_code_mode_o(par), .mode_setup_ok_o(setup_ok),
    .ref_level_o(ref_lvl), .active_phases_o(phases),
    .cycle_average_current_o(avg), .balance_trim_o(trim));

  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  function automatic logic [REF_W-1:0] ref_of(input logic [5:0] c);
    if (c < 6'h20) return REF_W'(15500 - 250 * int'(c));
    return REF_W'(7625 - 125 * (int'(c) - 32));
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic wait_core();
    int k = 0;
    while (core_en !== 1'h1 && k < 20) begin
      tick(1);
      k++;
    end
    `CHK("core_start", 1'h1, core_en)
  endtask

  // One trim update only: the check lands before the second tick
  task automatic check_run(input logic s, input logic [2:0] n);
    int sum = 0;
    logic [CUR_W-1:0] a;
    logic signed [ERR_W-1:0] e;
    for (int i = 0; i < n; i++) sum += 100 * (i + 1);
    a = CUR_W'(sum / n);
    `CHK("mode", s, par)
    `CHK("setup_ok", 1'h1, setup_ok)
    `CHK("aux_on", ~s, aux_en)
    `CHK("phases", n, phases)
    `CHK("avg", a, avg)
    for (int i = 0; i < MAX_PH; i++) begin
      e = $signed(ERR_W'(a)) - $signed(ERR_W'(100 * (i + 1)));
      // Kept apart from a conditional so the shift stays arithmetic
      if (i < n)
        e = e >>> FILT_SH;
      else
        e = '0;
      `CHK("trim", e, trim[i])
    end
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      $display("timeout");
      end_of_test();
    end
  end

  initial begin
    errors = 0;
    n_checks = 0;
    cyc = 0;
    rst_n = 1'h0;
    tick(8);
    `CHK("rst_phases", 3'h4, phases)
    `CHK("rst_mode", 1'h0, par)
    rst_n = 1'h1;
    foreach (rows[r]) begin
      i_host.set_enable(1'h0);
      i_host.set_pins(rows[r].sel, rows[r].s3, rows[r].s4, rows[r].code);
      tick(5);
      `CHK("off_core", 1'h0, core_en)
      `CHK("off_aux", 1'h0, aux_en)
      `CHK("off_trim", '0, trim)
      `CHK("ref", ref_of(rows[r].code), ref_lvl)
      tick(205);
      i_host.set_enable(1'h1);
      wait_core();
      tick(20);
      check_run(rows[r].sel, rows[r].ph);
      $display("row %0d done", r);
    end
    // Select and sense moves while enabled must not reach mode or count
    i_host.set_pins(1'h1, 1'h1, 1'h0, 6'h00);
    tick(10);
    `CHK("mode_held", 1'h0, par)
    `CHK("phases_held", 3'h4, phases)
    i_host.set_enable(1'h0);
    tick(5);
    `CHK("phases_low", 3'h2, phases)
    $display("hold test done");
    // Select moved high only lately: still captured, flagged as short setup
    i_host.set_pins(1'h1, 1'h0, 1'h0, 6'h3F);
    tick(10);
    i_host.set_enable(1'h1);
    tick(6);
    `CHK("late_mode", 1'h1, par)
    `CHK("late_aux", 1'h0, aux_en)
    `CHK("late_setup", 1'h0, setup_ok)
    $display("setup test done");
    for (int c = 0; c < 64; c++) begin
      i_host.set_pins(1'h0, 1'h0, 1'h0, 6'(c));
      tick(5);
      `CHK("ref_sweep", ref_of(6'(c)), ref_lvl)
    end
    $display("code sweep done");
    rst_n = 1'h0;
    #1;
    `CHK("rst_core", 1'h0, core_en)
    `CHK("rst_aux", 1'h0, aux_en)
    `CHK("rst_mode2", 1'h0, par)
    `CHK("rst_phases2", 3'h4, phases)
    $display("reset test done");
    end_of_test();
  end
endmodule
